// file: gpio_pad_config_subregs.sv
// Open-drain, high-drive and wake-source subregisters with the pad drive and wake logic.
//
// Functional notes
// R01 - Open-drain subregister reached through control register while subaddress is 03h.
// R02 - Open-drain bit 1 disables the pin's drive while it outputs 1; 0 keeps drive enabled.
// R03 - Open-drain setting applies to alternate-function driven pins as well.
// R04 - High-drive subregister reached through control register while subaddress is 04h.
// R05 - High-drive bit 1 selects high-current drive; 0 selects standard drive.
// R06 - High-drive selection acts on the pin, including alternate-function pins.
// R07 - Wake-source subregister reached through control register while subaddress is 05h.
// R08 - In stop mode, any edge on an enabled pin requests recovery.
// R09 - In stop mode, edges on disabled pins never request recovery.
// R10 - High-drive and wake-source subregisters are read/write and reset to zero.
// R11 - Open-drain pins never drive high; only the low level is driven.
// R12 - Alternate function bit 1 hands the pin over; 0 lets direction decide.
// R13 - Bit n of every subregister controls pin n independently.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_pad_consts.svh"

module gpio_pad_config_subregs #(
  parameter int PINS = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register access through the port address and port control registers.
  input wire gpio_pad_pkg::cfg_byte_t subaddr_i,
  input wire logic ctl_wr_i,
  input wire gpio_pad_pkg::cfg_byte_t ctl_wdata_i,
  input wire logic ctl_rd_i,
  output gpio_pad_pkg::cfg_byte_t ctl_rdata_o,
  output logic ctl_hit_o,
  // Pin control from the neighbouring port registers and peripherals.
  input wire logic [PINS-1:0] output_value_i,
  input wire logic [PINS-1:0] direction_bit_i,
  input wire logic [PINS-1:0] alt_function_bit_i,
  input wire logic [PINS-1:0] alt_out_i,
  input wire logic [PINS-1:0] alt_oe_i,
  input wire logic stop_mode_i,
  // Pad side.
  input wire logic [PINS-1:0] pin_in_i,
  output logic [PINS-1:0] pad_out_o,
  output logic [PINS-1:0] pad_oe_o,
  output logic [PINS-1:0] high_drive_o,
  output logic [PINS-1:0] pin_level_o,
  output logic wake_request_o
);

  import gpio_pad_pkg::*;

  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  if (PINS < 1 || PINS > `GPC_PINS_MAX) begin : g_bad_pins
    $error("PINS must lie between 1 and 8.");
  end

  // --------------------------------------------------------------------------
  // Subaddress decode
  // --------------------------------------------------------------------------
  function automatic subreg_sel_t decode_sub(input cfg_byte_t code);
    subreg_sel_t sel;
    sel = SEL_NONE;
    if (code == `GPC_SUB_OPEN_DRAIN) begin
      sel = SEL_OPEN_DRAIN;
    end else if (code == `GPC_SUB_HIGH_DRIVE) begin
      sel = SEL_HIGH_DRIVE;
    end else if (code == `GPC_SUB_WAKE_SOURCE) begin
      sel = SEL_WAKE_SOURCE;
    end
    return sel;
  endfunction : decode_sub

  subreg_sel_t sel;
  logic wr_open_drain;
  logic wr_high_drive;
  logic wr_wake_source;
  cfg_byte_t open_drain_select;
  cfg_byte_t high_drive_select;
  cfg_byte_t wake_source_enable;
  cfg_byte_t read_mux;

  // R01 - open-drain mapping
  // R04 - high-drive mapping
  // R07 - wake-source mapping
  assign sel = decode_sub(subaddr_i);
  assign wr_open_drain = ctl_wr_i && (sel == SEL_OPEN_DRAIN);
  assign wr_high_drive = ctl_wr_i && (sel == SEL_HIGH_DRIVE);
  assign wr_wake_source = ctl_wr_i && (sel == SEL_WAKE_SOURCE);

  // R10 - readback selection
  assign read_mux = (sel == SEL_OPEN_DRAIN) ? open_drain_select :
                    (sel == SEL_HIGH_DRIVE) ? high_drive_select :
                    (sel == SEL_WAKE_SOURCE) ? wake_source_enable : `GPC_READ_IDLE;

  // --------------------------------------------------------------------------
  // Subregisters
  // --------------------------------------------------------------------------
  // R10 - reset to zero
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      open_drain_select <= `GPC_OPEN_DRAIN_RESET;
      high_drive_select <= `GPC_HIGH_DRIVE_RESET;
      wake_source_enable <= `GPC_WAKE_SOURCE_RESET;
    end else begin
      if (wr_open_drain) begin
        open_drain_select <= ctl_wdata_i;
      end
      if (wr_high_drive) begin
        high_drive_select <= ctl_wdata_i;
      end
      if (wr_wake_source) begin
        wake_source_enable <= ctl_wdata_i;
      end
    end
  end

  // Read data is captured on the read strobe and held until the next one.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_rdata_o <= `GPC_READ_IDLE;
      ctl_hit_o <= 1'b0;
    end else begin
      if (ctl_rd_i) begin
        ctl_rdata_o <= read_mux;
      end
      ctl_hit_o <= (sel != SEL_NONE);
    end
  end

  // --------------------------------------------------------------------------
  // Pad drive
  // --------------------------------------------------------------------------
  logic [PINS-1:0] od_mask;
  logic [PINS-1:0] drive_en;
  logic [PINS-1:0] drive_val;
  logic [PINS-1:0] od_high;
  logic [PINS-1:0] next_pad_oe;

  // R13 - per-pin bit slices
  assign od_mask = open_drain_select[PINS-1:0];

  // R12 - alternate function takes the pin; a set direction bit means input
  assign drive_en = (alt_function_bit_i & alt_oe_i) | (~alt_function_bit_i & ~direction_bit_i);
  assign drive_val = (alt_function_bit_i & alt_out_i) | (~alt_function_bit_i & output_value_i);

  // R02 - high-level drive disabled on open-drain pins
  // R03 - alternate path included
  // R11 - only low is driven
  assign od_high = od_mask & drive_val;
  assign next_pad_oe = drive_en & ~od_high;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pad_out_o <= '0;
      pad_oe_o <= '0;
    end else begin
      pad_out_o <= drive_val;
      pad_oe_o <= next_pad_oe;
    end
  end

  // R05 - high drive select
  // R06 - acts on every pin
  assign high_drive_o = high_drive_select[PINS-1:0];

  // --------------------------------------------------------------------------
  // Stop mode recovery
  // --------------------------------------------------------------------------
  logic [PINS-1:0] pin_edge;
  logic [PINS-1:0] wake_mask;
  logic wake_hit;

  gpio_pin_sync #(
    .PINS(PINS)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_async_i(pin_in_i),
    .pin_level_o(pin_level_o),
    .pin_edge_o(pin_edge)
  );

  // R08 - enabled pins wake
  // R09 - disabled pins ignored
  assign wake_mask = wake_source_enable[PINS-1:0];
  assign wake_hit = stop_mode_i && ((pin_edge & wake_mask) != '0);

  // The request holds until stop mode ends; a hit needs stop mode, so none can override that clear.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_request_o <= 1'b0;
    end else begin
      wake_request_o <= wake_hit | (wake_request_o & stop_mode_i);
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_od_write_map: assert property (@(posedge core_clk_i) disable iff (rst_i) // R01
    ctl_wr_i && subaddr_i == `GPC_SUB_OPEN_DRAIN |=> open_drain_select == $past(ctl_wdata_i))
    else $error("Open-drain subregister missed a write at its subaddress.");

  a_hd_write_map: assert property (@(posedge core_clk_i) disable iff (rst_i) // R04
    ctl_wr_i && subaddr_i == `GPC_SUB_HIGH_DRIVE |=> high_drive_select == $past(ctl_wdata_i))
    else $error("High-drive subregister missed a write at its subaddress.");

  a_wake_write_map: assert property (@(posedge core_clk_i) disable iff (rst_i) // R07
    ctl_wr_i && subaddr_i == `GPC_SUB_WAKE_SOURCE |=> wake_source_enable == $past(ctl_wdata_i))
    else $error("Wake-source subregister missed a write at its subaddress.");

  a_od_no_high: assert property (@(posedge core_clk_i) disable iff (rst_i) // R11
    1 |=> ((pad_oe_o & pad_out_o & $past(od_mask)) == '0))
    else $error("Open-drain pin drove a high level.");

  a_drive_kept_on: assert property (@(posedge core_clk_i) disable iff (rst_i) // R02
    1 |=> (($past(drive_en) & ~$past(od_mask) & ~pad_oe_o) == '0))
    else $error("Push-pull output lost its drive.");

  a_alt_pin_data: assert property (@(posedge core_clk_i) disable iff (rst_i) // R12
    1 |=> (($past(alt_function_bit_i) & (pad_out_o ^ $past(alt_out_i))) == '0))
    else $error("Alternate function pin does not follow its peripheral.");

  a_wake_enabled: assert property (@(posedge core_clk_i) disable iff (rst_i) // R08
    stop_mode_i && ((pin_edge & wake_mask) != '0) |=> wake_request_o)
    else $error("Enabled pin edge in stop mode gave no wake request.");

  a_wake_ignored: assert property (@(posedge core_clk_i) disable iff (rst_i) // R09
    !wake_request_o && ((pin_edge & wake_mask) == '0) |=> !wake_request_o)
    else $error("Wake request rose without an enabled pin edge.");

  a_reset_zero: assert property (@(posedge core_clk_i) // R10
    $past(rst_i) |-> (high_drive_select == '0) && (wake_source_enable == '0))
    else $error("Subregisters not zero after reset.");

  a_read_back: assert property (@(posedge core_clk_i) disable iff (rst_i) // R10
    ctl_rd_i && subaddr_i == `GPC_SUB_HIGH_DRIVE |=> ctl_rdata_o == $past(high_drive_select))
    else $error("High-drive readback mismatch.");

endmodule : gpio_pad_config_subregs

`default_nettype wire

// file: gpio_pad_consts.svh
// Subaddress codes, reset values and widths of the pad configuration subregisters.
`ifndef GPIO_PAD_CONSTS_SVH
`define GPIO_PAD_CONSTS_SVH

// ----------------------------------------------------------------------------
// Subaddress codes placed in the port address register
// ----------------------------------------------------------------------------
`define GPC_SUB_OPEN_DRAIN 8'h03
`define GPC_SUB_HIGH_DRIVE 8'h04
`define GPC_SUB_WAKE_SOURCE 8'h05

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define GPC_DATA_WIDTH 8
`define GPC_PINS_MAX 8
`define GPC_OPEN_DRAIN_RESET 8'h00
`define GPC_HIGH_DRIVE_RESET 8'h00
`define GPC_WAKE_SOURCE_RESET 8'h00
`define GPC_READ_IDLE 8'h00

`endif

// file: gpio_pad_pkg.sv
// Types shared by the pad configuration logic.
`default_nettype none
`include "gpio_pad_consts.svh"

package gpio_pad_pkg;

  typedef logic [`GPC_DATA_WIDTH-1:0] cfg_byte_t;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_OPEN_DRAIN,
    SEL_HIGH_DRIVE,
    SEL_WAKE_SOURCE
  } subreg_sel_t;

endpackage : gpio_pad_pkg

`default_nettype wire

// file: gpio_pin_sync.sv
// Pin input synchroniser with agreement filter and change pulse.
`timescale 1ns/1ns
`default_nettype none

module gpio_pin_sync #(
  parameter int PINS = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [PINS-1:0] pin_async_i,
  output logic [PINS-1:0] pin_level_o,
  output logic [PINS-1:0] pin_edge_o
);

  logic [PINS-1:0] stage1;
  logic [PINS-1:0] stage2;
  logic [PINS-1:0] stage3;
  logic [PINS-1:0] agree;
  logic [PINS-1:0] next_level;

  // The filter needs at least one pin to act on.
  if (PINS < 1) begin : g_bad_pins
    $error("PINS must be at least 1.");
  end

  // A bit only moves once the second and third stages hold the same value.
  assign agree = ~(stage2 ^ stage3);
  assign next_level = (agree & stage2) | (~agree & pin_level_o);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin_async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_level_o <= '0;
      pin_edge_o <= '0;
    end else begin
      pin_level_o <= next_level;
      pin_edge_o <= next_level ^ pin_level_o;
    end
  end

  a_edge_agrees: assert property (@(posedge core_clk_i) disable iff (rst_i)
    1 |=> ((pin_edge_o & ~$past(agree)) == '0))
    else $error("Pin change reported while sync stages disagreed.");

endmodule : gpio_pin_sync

`default_nettype wire

// file: pad_ext_model.sv
// Board circuitry on the port pins: an external source per pin and a pull-up on every line.
`timescale 1ns/1ns
`default_nettype none

module pad_ext_model (
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] pin_o
);
  // A line left undriven by both parties rises through its pull-up.
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      pin_o[n] = pad_oe_i[n] ? pad_out_i[n] : (ext_en_i[n] ? ext_val_i[n] : 1'b1);
    end
  end
endmodule : pad_ext_model

`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the pad configuration subregisters.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_pad_consts.svh"

module tb_top;
  import gpio_pad_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr = 1'b0, rd = 1'b0, stop = 1'b0, hit, wake;
  cfg_byte_t subaddr = 8'h00, wdata = 8'h00, rdata, out_val = 8'h00, dir = 8'hFF, alt_fn = 8'h00;
  cfg_byte_t alt_out = 8'h00, alt_oe = 8'h00, ext_val = 8'h00, ext_en = 8'h00;
  cfg_byte_t pin_in, pad_out, pad_oe, high_drive, pin_level;
  int err_count = 0;
  int tests_run = 0;

  always #2 core_clk_i = ~core_clk_i;

  gpio_pad_config_subregs #(.PINS(8)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .subaddr_i(subaddr),
    .ctl_wr_i(wr), .ctl_wdata_i(wdata), .ctl_rd_i(rd), .ctl_rdata_o(rdata), .ctl_hit_o(hit),
    .output_value_i(out_val), .direction_bit_i(dir), .alt_function_bit_i(alt_fn), .alt_out_i(alt_out),
    .alt_oe_i(alt_oe), .stop_mode_i(stop), .pin_in_i(pin_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
    .high_drive_o(high_drive), .pin_level_o(pin_level), .wake_request_o(wake));

  pad_ext_model board (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_val_i(ext_val), .ext_en_i(ext_en),
    .pin_o(pin_in));

  // --------------------------------------------------------------------------
  // Access and checking tasks
  // --------------------------------------------------------------------------
  task automatic summarize;
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input cfg_byte_t exp, input cfg_byte_t got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input cfg_byte_t a, input cfg_byte_t d);
    @(posedge core_clk_i);
    subaddr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input cfg_byte_t a, input cfg_byte_t exp, input logic exp_hit);
    @(posedge core_clk_i);
    subaddr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    @(negedge core_clk_i);
    chk("readback", exp, rdata);
    chk("hit", {7'h00, exp_hit}, {7'h00, hit});
  endtask : rd_reg

  task automatic drive_pad(input cfg_byte_t d, input cfg_byte_t v, input cfg_byte_t af, input cfg_byte_t ao,
                           input cfg_byte_t aoe, input cfg_byte_t exp_out, input cfg_byte_t exp_oe);
    @(posedge core_clk_i);
    dir <= d;
    out_val <= v;
    alt_fn <= af;
    alt_out <= ao;
    alt_oe <= aoe;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("pad_out", exp_out, pad_out);
    chk("pad_oe", exp_oe, pad_oe);
  endtask : drive_pad

  // Waits a bounded time for the recovery request; a miss ends the run.
  task automatic wake_wait;
    for (int i = 0; i < 12 && wake !== 1'b1; i++) @(negedge core_clk_i);
    tests_run++;
    if (wake !== 1'b1) begin
      err_count++;
      $display("MISMATCH wake expected 1 seen %b", wake);
      summarize();
    end
  endtask : wake_wait

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    automatic cfg_byte_t subs[3] = '{`GPC_SUB_OPEN_DRAIN, `GPC_SUB_HIGH_DRIVE, `GPC_SUB_WAKE_SOURCE};
    automatic cfg_byte_t pats[3] = '{8'h5A, 8'hA5, 8'h81};
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    chk("high_drive", 8'h00, high_drive);
    for (int k = 0; k < 3; k++) rd_reg(subs[k], 8'h00, 1'b1);
    for (int k = 0; k < 3; k++) wr_reg(subs[k], pats[k]);
    for (int k = 0; k < 3; k++) rd_reg(subs[k], pats[k], 1'b1);
    wr_reg(8'h06, 8'hFF);
    rd_reg(8'h06, 8'h00, 1'b0);
    rd_reg(`GPC_SUB_HIGH_DRIVE, 8'hA5, 1'b1);
    chk("high_drive", 8'hA5, high_drive);
    drive_pad(8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hA5);
    drive_pad(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF);
    drive_pad(8'hFF, 8'h0F, 8'hF0, 8'hFF, 8'hF0, 8'hFF, 8'hA0);
    chk("high_drive", 8'hA5, high_drive);
    @(posedge core_clk_i);
    dir <= 8'hFF;
    alt_fn <= 8'h00;
    ext_en <= 8'hFF;
    repeat (8) @(posedge core_clk_i);
    stop <= 1'b1;
    ext_val <= 8'h02;
    repeat (12) @(negedge core_clk_i);
    chk("pin_level", 8'h02, pin_level);
    chk("wake", 8'h00, {7'h00, wake});
    @(posedge core_clk_i);
    ext_val <= 8'h82;
    wake_wait();
    @(posedge core_clk_i);
    stop <= 1'b0;
    repeat (3) @(negedge core_clk_i);
    chk("wake", 8'h00, {7'h00, wake});
    @(posedge core_clk_i);
    stop <= 1'b1;
    ext_val <= 8'h02;
    wake_wait();
    summarize();
  end
endmodule : tb_top

`default_nettype wire
